// ==== pfbo_pkg.sv ====
package pfbo_pkg;
   // ----------------------------------------------------------------
   // Register map of the controller (word aligned byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] PFBO_REG_CTRL   = 8'h00;
   localparam logic [7:0] PFBO_REG_ADDR   = 8'h04;
   localparam logic [7:0] PFBO_REG_WDATA  = 8'h08;
   localparam logic [7:0] PFBO_REG_RDATA  = 8'h0c;
   localparam logic [7:0] PFBO_REG_STATUS = 8'h10;
   localparam logic [7:0] PFBO_REG_CMD    = 8'h14;

   // CTRL field positions
   localparam int PFBO_CTRL_WORD   = 0;  // Word width when set
   localparam int PFBO_CTRL_RESET  = 1;  // Drive hardware reset low
   localparam int PFBO_CTRL_ACCEL  = 2;  // Raise accelerate level
   localparam int PFBO_CTRL_WPHIGH = 3;  // Protect pin high when not accelerating
   localparam int PFBO_CTRL_IDLVL  = 4;  // Reset pin at id level for protect writes
   localparam logic [31:0] PFBO_CTRL_RESET_VAL = 32'h0000_0009;

   // CMD codes
   localparam logic [1:0] PFBO_CMD_READ  = 2'h1;
   localparam logic [1:0] PFBO_CMD_WRITE = 2'h2;

   // ----------------------------------------------------------------
   // Flash timing, ns and derived 50 MHz cycles
   // ----------------------------------------------------------------
   localparam int PFBO_CLK_NS   = 20;
   localparam int PFBO_TACC_NS  = 70;   // Access time, slow grade
   localparam int PFBO_TWP_NS   = 35;   // Write strobe low width
   localparam int PFBO_TSET_NS  = 20;   // Address setup and recovery
   localparam int PFBO_ACC_CYC  = (PFBO_TACC_NS + PFBO_CLK_NS - 1) / PFBO_CLK_NS;
   localparam int PFBO_WP_CYC   = (PFBO_TWP_NS + PFBO_CLK_NS - 1) / PFBO_CLK_NS;
   localparam int PFBO_SET_CYC  = (PFBO_TSET_NS + PFBO_CLK_NS - 1) / PFBO_CLK_NS;
   localparam logic [3:0] PFBO_ACC_CNT = 4'(PFBO_ACC_CYC);
   localparam logic [3:0] PFBO_WP_CNT  = 4'(PFBO_WP_CYC);
   localparam logic [3:0] PFBO_SET_CNT = 4'(PFBO_SET_CYC);

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      PFBO_IDLE  = 5'b00001,
      PFBO_SETUP = 5'b00010,
      PFBO_RDACC = 5'b00100,
      PFBO_WRLOW = 5'b01000,
      PFBO_RECOV = 5'b10000
   } pfbo_state_t;

   typedef struct packed {
      logic chip_select_n;
      logic read_enable_n;
      logic write_strobe_n;
   } pfbo_ctl_t;
endpackage : pfbo_pkg

// ==== pfbo_host.sv ====
// Overview of operation
// RULE1 - Reads drive chip select and read enable low, write strobe high.
// RULE2 - Flash starts in array read; no command is needed before reads.
// RULE3 - Writes drive write strobe and chip select low, read enable high.
// RULE4 - Each written command, address and data goes to the flash command latch.
// RULE5 - Width select high gives sixteen active data lines.
// RULE6 - Width select low uses low byte; top data line carries lsb address. Code enables that line only in write cycles; flash_dq_oe_n stays high on reads.
// RULE7 - Address A20:A0 in word mode, A20:A-1 in byte mode.
// RULE8 - Chip select and reset high put the flash in standby.
// RULE9 - After standby a full chip select access time precedes valid data.
// RULE10 - Program or erase continues when chip select is released.
// RULE11 - Stable address gives automatic sleep; data stays latched.
// RULE12 - In fast program mode one program takes two writes.
// RULE13 - Accelerate level enters fast program and unprotects sectors.
// RULE14 - Protect pin low keeps two outer boot sectors protected.
// RULE15 - Accelerate level only for accelerated programming; pin always driven.
// RULE16 - Autoselect sequence gives id codes with normal read timing.
// RULE17 - Reads allowed in one bank while another programs or erases.
// RULE18 - Each bank stays in array read until a write changes the latch.
// RULE19 - Erase of one sector, several sectors or the whole array.
// RULE20 - Sector protect write: id level reset, A6 low, A1 high, A0 low.
// RULE21 - Sector unprotect write: same levels with A6 high.
// RULE22 - Four banks selected by upper address bits.
// RULE23 - Never read enable and write strobe low together under chip select.
`timescale 1ns/1ns
`default_nettype none
module pfbo_host
   import pfbo_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        arst_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Flash pins
   output logic      [20:0] flash_addr,
   input  wire logic [15:0] flash_dq_in,
   output logic      [15:0] flash_dq_out,
   output logic             flash_dq_oe_n,
   output logic             chip_select_n,
   output logic             read_enable_n,
   output logic             write_strobe_n,
   output logic             hw_reset_n,
   output logic             reset_id_level,
   output logic             width_select_n,
   output logic             protect_accel_pin,
   output logic             protect_accel_high_voltage,
   input  wire logic        ready_busy_n
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl;
   logic [21:0] addr_reg;     // Bit 0 is lsb_byte_address in byte mode
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        busy;
   logic        done;
   pfbo_state_t state;
   logic [3:0]  cnt;
   logic        op_write;
   pfbo_ctl_t   ctl;

   // AHB address phase capture
   logic        dp_valid;
   logic        dp_write;
   logic [7:0]  dp_addr;
   logic        take;

   assign take = hsel && hready && htrans[1];

   // Decode a register offset to a one-hot index; used for read and write
   function automatic logic [5:0] reg_hit(input logic [7:0] a);
      logic [5:0] h;
      h = 6'h00;
      if (a == PFBO_REG_CTRL) begin
         h = 6'h01;
      end else if (a == PFBO_REG_ADDR) begin
         h = 6'h02;
      end else if (a == PFBO_REG_WDATA) begin
         h = 6'h04;
      end else if (a == PFBO_REG_RDATA) begin
         h = 6'h08;
      end else if (a == PFBO_REG_STATUS) begin
         h = 6'h10;
      end else if (a == PFBO_REG_CMD) begin
         h = 6'h20;
      end
      return h;
   endfunction : reg_hit

   // ----------------------------------------------------------------
   // Bus slave: zero wait states, always OKAY
   // ----------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr  <= 8'h00;
      end else if (hready) begin
         dp_valid <= take;
         dp_write <= hwrite;
         dp_addr  <= haddr;
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      logic [5:0] h;
      h = reg_hit(dp_addr);
      hrdata = 32'h0000_0000;
      if (h[0]) begin
         hrdata = ctrl;
      end else if (h[1]) begin
         hrdata = {10'h000, addr_reg};
      end else if (h[2]) begin
         hrdata = {16'h0000, wdata};
      end else if (h[3]) begin
         hrdata = {16'h0000, rdata};
      end else if (h[4]) begin
         // Busy pin stays visible after deselect; bus cycles may run meanwhile [RULE10] [RULE17]
         hrdata = {29'h0, ready_busy_n, done, busy};
      end
   end

   logic wr_ctrl;
   logic wr_addr;
   logic wr_wdata;
   logic wr_cmd;
   logic rd_rdata;
   always_comb begin
      logic [5:0] h;
      h = reg_hit(dp_addr);
      wr_ctrl  = dp_valid && dp_write && h[0];
      wr_addr  = dp_valid && dp_write && h[1] && !busy;
      wr_wdata = dp_valid && dp_write && h[2] && !busy;
      wr_cmd   = dp_valid && dp_write && h[5] && !busy;
      rd_rdata = dp_valid && !dp_write && h[3];
   end

   // Control register; accel and reset can change at any time
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= PFBO_CTRL_RESET_VAL;
      end else if (wr_ctrl) begin
         ctrl <= {27'h0, hwdata[4:0]};
      end
   end

   // Address and write data; ignored while a cycle runs
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         addr_reg <= 22'h000000;
         wdata    <= 16'h0000;
      end else begin
         if (wr_addr) begin
            addr_reg <= hwdata[21:0];
         end
         if (wr_wdata) begin
            wdata <= hwdata[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Flash bus cycle engine
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state    <= PFBO_IDLE;
         cnt      <= 4'h0;
         op_write <= 1'b0;
         busy     <= 1'b0;
      end else begin
         case (state)
            PFBO_IDLE: begin
               // Reads need no preceding command: flash is in array read [RULE2] [RULE18]
               if (wr_cmd && (hwdata[1:0] == PFBO_CMD_READ ||
                              hwdata[1:0] == PFBO_CMD_WRITE)) begin
                  // Program, erase and id sequences are all series of write cycles [RULE19]
                  op_write <= (hwdata[1:0] == PFBO_CMD_WRITE);
                  busy     <= 1'b1;
                  cnt      <= PFBO_SET_CNT;
                  state    <= PFBO_SETUP;
               end
            end
            PFBO_SETUP: begin
               if (cnt > 4'h1) begin
                  cnt <= cnt - 4'h1;
               end else if (op_write) begin
                  cnt   <= PFBO_WP_CNT;
                  state <= PFBO_WRLOW;
               end else begin
                  // Full chip select access time, covers standby and id reads [RULE9] [RULE16]
                  cnt   <= PFBO_ACC_CNT;
                  state <= PFBO_RDACC;
               end
            end
            PFBO_RDACC: begin
               if (cnt > 4'h1) begin
                  cnt <= cnt - 4'h1;
               end else begin
                  cnt   <= PFBO_SET_CNT;
                  state <= PFBO_RECOV;
               end
            end
            PFBO_WRLOW: begin
               if (cnt > 4'h1) begin
                  cnt <= cnt - 4'h1;
               end else begin
                  cnt   <= PFBO_SET_CNT;
                  state <= PFBO_RECOV;
               end
            end
            PFBO_RECOV: begin
               if (cnt > 4'h1) begin
                  cnt <= cnt - 4'h1;
               end else begin
                  busy  <= 1'b0;
                  state <= PFBO_IDLE;
               end
            end
            default: begin
               busy  <= 1'b0;
               state <= PFBO_IDLE;
            end
         endcase
      end
   end

   // Read data sampled at the end of the access; sleep keeps it latched [RULE11]
   // The strobe pin lags the state by one flop, so the first recovery edge is the
   // last one with read enable low and the full access time behind it
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 16'h0000;
      end else if (state == PFBO_RECOV && cnt == PFBO_SET_CNT && !op_write) begin
         // Byte mode drives only the low lane [RULE6]
         rdata <= ctrl[PFBO_CTRL_WORD] ? flash_dq_in : {8'h00, flash_dq_in[7:0]};
      end
   end

   // Done flag: set by cycle end wins over a clear by reading rdata
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         done <= 1'b0;
      end else if (state == PFBO_RECOV && cnt == 4'h1) begin
         done <= 1'b1;
      end else if (rd_rdata || wr_cmd) begin
         done <= 1'b0;
      end
   end

   // Strobe decode; read enable and write strobe never low together [RULE23]
   always_comb begin
      ctl.chip_select_n  = 1'b1;   // Idle deselect gives standby [RULE8]
      ctl.read_enable_n  = 1'b1;
      ctl.write_strobe_n = 1'b1;
      if (state == PFBO_RDACC) begin
         ctl.chip_select_n = 1'b0; // [RULE1]
         ctl.read_enable_n = 1'b0; // [RULE1]
      end else if (state == PFBO_WRLOW) begin
         ctl.chip_select_n  = 1'b0; // [RULE3]
         ctl.write_strobe_n = 1'b0; // Command latched on rising edge [RULE3] [RULE4]
      end else if (state != PFBO_IDLE) begin
         ctl.chip_select_n = 1'b0;
      end
   end

   // Pin registers; data outputs come from flip-flops
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         chip_select_n  <= 1'b1;
         read_enable_n  <= 1'b1;
         write_strobe_n <= 1'b1;
         flash_dq_oe_n  <= 1'b1;
         flash_dq_out   <= 16'h0000;
         flash_addr     <= 21'h000000;
      end else begin
         chip_select_n  <= ctl.chip_select_n;
         read_enable_n  <= ctl.read_enable_n;
         write_strobe_n <= ctl.write_strobe_n;
         flash_dq_oe_n  <= !(op_write && state != PFBO_IDLE);
         // Word mode A20:A0; byte mode A20:A-1 with A-1 on top bit of flash_dq_out, enabled only in write cycles [RULE5] [RULE7]
         if (ctrl[PFBO_CTRL_WORD]) begin
            flash_addr   <= addr_reg[20:0]; // Bank bits ride on the upper address [RULE22]
            flash_dq_out <= wdata;
         end else begin
            flash_addr   <= addr_reg[21:1];
            flash_dq_out <= {addr_reg[0], 7'h00, wdata[7:0]}; // [RULE6]
         end
      end
   end

   // Static control pins
   always_comb begin
      width_select_n = ctrl[PFBO_CTRL_WORD];
      hw_reset_n     = !ctrl[PFBO_CTRL_RESET];
      // Protect/unprotect writes raise reset to id level; address bits by software [RULE20] [RULE21]
      reset_id_level = ctrl[PFBO_CTRL_IDLVL] && !ctrl[PFBO_CTRL_RESET];
      // Pin always driven; high voltage only on request for fast programming [RULE13] [RULE15]
      protect_accel_high_voltage = ctrl[PFBO_CTRL_ACCEL]; // Two-write programs [RULE12]
      protect_accel_pin = ctrl[PFBO_CTRL_WPHIGH] || ctrl[PFBO_CTRL_ACCEL]; // [RULE14]
   end
endmodule : pfbo_host
`default_nettype wire

// ==== pfbo_host_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Flash pin checker
// ----------------------------------------------------------------
module pfbo_host_monitor (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic flash_dq_oe_n,
   input wire logic chip_select_n,
   input wire logic read_enable_n,
   input wire logic write_strobe_n,
   input wire logic hw_reset_n,
   input wire logic reset_id_level,
   input wire logic width_select_n,
   input wire logic protect_accel_pin,
   input wire logic protect_accel_high_voltage
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Strobe shapes: four cycles of access, two of write low
   sequence read_pulse;
      !read_enable_n [*4] ##1 read_enable_n;
   endsequence
   sequence strobe_pulse;
      !write_strobe_n [*2] ##1 write_strobe_n;
   endsequence
   a_no_rd_wr_clash: assert property (!(!chip_select_n && !read_enable_n
      && !write_strobe_n)) else $error("read and write strobes low together");
   a_read_levels: assert property (!read_enable_n |-> !chip_select_n && write_strobe_n)
      else $error("read strobe without select");
   a_write_levels: assert property (!write_strobe_n |-> !chip_select_n && read_enable_n)
      else $error("write strobe without select");
   a_read_access: assert property ($fell(read_enable_n) |-> read_pulse)
      else $error("read strobe too short");
   a_read_setup: assert property ($fell(read_enable_n) |-> $past(chip_select_n) == 1'b0)
      else $error("select not ahead of read strobe");
   a_strobe_width: assert property ($fell(write_strobe_n) |-> strobe_pulse)
      else $error("write strobe width wrong");
   a_write_latch: assert property ($rose(write_strobe_n) |-> !chip_select_n && !flash_dq_oe_n)
      else $error("select or data dropped before strobe rise");
   a_no_contention: assert property (!read_enable_n && width_select_n |-> flash_dq_oe_n)
      else $error("host drives data during word read");
   a_accel_level: assert property (protect_accel_high_voltage |-> protect_accel_pin)
      else $error("accelerate level with pin low");
   a_id_level: assert property (reset_id_level |-> hw_reset_n)
      else $error("id level while in reset");
endmodule : pfbo_host_monitor
bind pfbo_host pfbo_host_monitor u_mon (.clock(clock), .arst_n(arst_n),
   .flash_dq_oe_n(flash_dq_oe_n), .chip_select_n(chip_select_n),
   .read_enable_n(read_enable_n), .write_strobe_n(write_strobe_n),
   .hw_reset_n(hw_reset_n), .reset_id_level(reset_id_level),
   .width_select_n(width_select_n), .protect_accel_pin(protect_accel_pin),
   .protect_accel_high_voltage(protect_accel_high_voltage));
`default_nettype wire

// ==== pfbo_flash_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Behavioural flash device
// ----------------------------------------------------------------
module pfbo_flash_model #(parameter int ACC_NS = 65) (
   input wire logic [20:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic        chip_select_n,
   input wire logic        read_enable_n,
   input wire logic        write_strobe_n,
   input wire logic        hw_reset_n,
   input wire logic        width_select_n,
   input wire logic        protect_accel_high_voltage,
   output logic     [15:0] flash_dq_in,
   output var logic        ready_busy_n
);
   logic [15:0] mem [logic [20:0]];
   logic [15:0] w, rd;
   logic [23:0] hist;
   wire         drive = !chip_select_n && !read_enable_n && hw_reset_n;
   wire         drive_d;
   int          n_wr = 0;  // Bumped on each store so the array word is looked up again
   initial ready_busy_n = 1'b1;
   initial hist = '0;
   // Array data by default, no command needed
   always @(flash_addr or n_wr)
      w = mem.exists(flash_addr) ? mem[flash_addr] : 16'(flash_addr) ^ 16'h5a5a;
   // Byte mode: low lane only, top lane carries A-1, upper lanes garbage
   always @* rd = width_select_n ? w : {~w[15:8], flash_dq_out[15] ? w[15:8] : w[7:0]};
   // Data only after the access time; otherwise never the old value
   assign #(ACC_NS) drive_d = drive;
   assign flash_dq_in = (drive && drive_d) ? rd : ~rd;
   // Command latch; busy runs on even if deselected
   always @(posedge write_strobe_n or negedge hw_reset_n) begin
      if (!hw_reset_n) begin
         hist = '0;
      end else if (!chip_select_n && read_enable_n) begin
         if (hist[7:0] == 8'ha0 && (protect_accel_high_voltage || hist[23:8] == 16'haa55)) begin
            mem[flash_addr] = w & flash_dq_out;
            n_wr = n_wr + 1;
            hist = '0;
            ready_busy_n = 1'b0;
            ready_busy_n <= #400 1'b1;
         end else begin
            hist = {hist[15:0], flash_dq_out[7:0]};
         end
      end
   end
endmodule : pfbo_flash_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import pfbo_pkg::*;
   logic clock = 0, arst_n = 0, hsel = 1, hwrite = 0;
   logic [7:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 0, q;
   logic [21:0] a;
   logic [15:0] d;
   wire logic [31:0] hrdata;
   wire logic hready, hreadyout, hresp, oe_n, cs_n, re_n, ws_n, rst_n, idl, wsel, wp, hv, rb_n;
   wire logic [20:0] fa;
   wire logic [15:0] dq_in, dq_out;
   int fail_count = 0, num_checks = 0;
   assign hready = hreadyout;
   always #10 clock = ~clock;
   pfbo_host dut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .flash_addr(fa), .flash_dq_in(dq_in),
      .flash_dq_out(dq_out), .flash_dq_oe_n(oe_n), .chip_select_n(cs_n), .read_enable_n(re_n),
      .write_strobe_n(ws_n), .hw_reset_n(rst_n), .reset_id_level(idl), .width_select_n(wsel),
      .protect_accel_pin(wp), .protect_accel_high_voltage(hv), .ready_busy_n(rb_n));
   pfbo_flash_model flash (.flash_addr(fa), .flash_dq_out(dq_out), .chip_select_n(cs_n),
      .read_enable_n(re_n), .write_strobe_n(ws_n), .hw_reset_n(rst_n), .width_select_n(wsel),
      .protect_accel_high_voltage(hv), .flash_dq_in(dq_in), .ready_busy_n(rb_n));
   // Expected array word of an untouched location
   function automatic logic [15:0] ew(input logic [20:0] x);
      return x[15:0] ^ 16'h5a5a;
   endfunction : ew
   // One AHB single transfer; read data lands in q
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      haddr <= ad;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hready !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // One flash cycle; the second address write is refused while busy
   task automatic fcyc(input logic [1:0] c, input logic [21:0] ad, input logic [15:0] wd);
      bus(1, PFBO_REG_ADDR, 32'(ad));
      bus(1, PFBO_REG_WDATA, 32'(wd));
      bus(1, PFBO_REG_CMD, 32'(c));
      bus(1, PFBO_REG_ADDR, ~32'(ad));
      do bus(0, PFBO_REG_STATUS, 0); while (q[0] !== 1'b0);
      chk("done", 32'h2, q & 32'h3);
      do bus(0, PFBO_REG_STATUS, 0); while (q[2] !== 1'b1);
      bus(0, PFBO_REG_ADDR, 0);
      chk("addr", 32'(ad), q);
      if (c == PFBO_CMD_READ) bus(0, PFBO_REG_RDATA, 0);
   endtask : fcyc
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   // Watchdog against a hung handshake
   initial begin
      #400000;
      fail_count++;
      end_of_test;
   end
   initial begin
      void'($urandom(64));
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      bus(0, PFBO_REG_CTRL, 0);
      chk("ctrl", PFBO_CTRL_RESET_VAL, q);
      chk("hresp", 0, 32'(hresp));
      bus(0, 8'h1c, 0);
      chk("unmapped", 0, q);
      chk("pins", 32'h0000_000e, 32'({wsel, rst_n, wp, hv}));
      repeat (4) begin
         a = 22'($urandom) & 22'h0fffff;
         fcyc(PFBO_CMD_READ, a, 0);
         chk("word", 32'(ew(a[20:0])), q);
      end
      // Normal program takes four writes
      a = 22'($urandom) | 22'h100000;
      d = 16'($urandom);
      fcyc(PFBO_CMD_WRITE, 22'h555, 16'haa);
      fcyc(PFBO_CMD_WRITE, 22'h2aa, 16'h55);
      fcyc(PFBO_CMD_WRITE, 22'h555, 16'ha0);
      fcyc(PFBO_CMD_WRITE, a, d);
      fcyc(PFBO_CMD_READ, a, 0);
      chk("program", 32'(ew(a[20:0]) & d), q);
      // Reset pulse flushes a half sequence
      fcyc(PFBO_CMD_WRITE, 22'h555, 16'haa);
      fcyc(PFBO_CMD_WRITE, 22'h2aa, 16'h55);
      bus(1, PFBO_REG_CTRL, 32'h0b);
      @(posedge clock);
      chk("reset pin", 0, 32'(rst_n));
      bus(1, PFBO_REG_CTRL, 32'h09);
      a = a ^ 22'h000101;
      fcyc(PFBO_CMD_WRITE, 22'h555, 16'ha0);
      fcyc(PFBO_CMD_WRITE, a, 16'h0);
      fcyc(PFBO_CMD_READ, a, 0);
      chk("no program", 32'(ew(a[20:0])), q);
      // Accelerated program takes two writes
      bus(1, PFBO_REG_CTRL, 32'h0d);
      @(posedge clock);
      chk("accel", 32'h3, 32'({wp, hv}));
      fcyc(PFBO_CMD_WRITE, 22'h555, 16'ha0);
      fcyc(PFBO_CMD_WRITE, a, d);
      fcyc(PFBO_CMD_READ, a, 0);
      chk("fast", 32'(ew(a[20:0]) & d), q);
      // Protect and unprotect writes at id level
      bus(1, PFBO_REG_CTRL, 32'h19);
      @(posedge clock);
      chk("id level", 32'h6, 32'({idl, rst_n, hv}));
      fcyc(PFBO_CMD_WRITE, 22'h040002, 16'h0);
      fcyc(PFBO_CMD_WRITE, 22'h040042, 16'h0);
      // Byte mode reads
      bus(1, PFBO_REG_CTRL, 32'h08);
      @(posedge clock);
      chk("byte pin", 0, 32'(wsel));
      repeat (4) begin
         a = 22'($urandom) & 22'h1fffff;
         d = ew(a[21:1]);
         fcyc(PFBO_CMD_READ, a, 0);
         chk("byte", a[0] ? 32'(d[15:8]) : 32'(d[7:0]), q);
      end
      end_of_test;
   end
endmodule : tb_top
`default_nettype wire
